/* File: design/csc_pkg.sv */
package csc_pkg;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned ALERT_US     = 256;
  localparam int unsigned ALERT_CYCLES = ALERT_US * CLK_MHZ;
  localparam int unsigned CNT_W        = 16;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_LIMIT   = 8'h04;
  localparam logic [7:0] OFS_VWIN    = 8'h08;
  localparam logic [7:0] OFS_TWIN    = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_EFF     = 8'h14;
  localparam logic [7:0] OFS_INT_ST  = 8'h18;
  localparam logic [7:0] OFS_INT_CLR = 8'h1c;
  localparam logic [7:0] OFS_INT_EN  = 8'h20;

  localparam int unsigned B_CHG_EN   = 0;
  localparam int unsigned B_STAT_OFF = 1;
  localparam int unsigned B_OK_OFF   = 2;
  localparam int unsigned B_ALW_OFF  = 3;
  localparam int unsigned B_CLIM_EN  = 4;
  localparam int unsigned B_ILIM_EN  = 5;
  localparam int unsigned B_FORCE_A  = 8;
  localparam int unsigned B_FORCE_B  = 9;
  localparam int unsigned B_FORCE_C  = 10;
  localparam int unsigned B_FORCE_D  = 11;

  localparam int unsigned EV_STATE = 0;
  localparam int unsigned EV_INOK  = 1;
  localparam int unsigned EV_TEMP  = 2;
  localparam int unsigned EV_HIZ   = 3;
  localparam int unsigned EV_N     = 4;

  localparam logic [11:0] CTRL_RST  = 12'h031;
  localparam logic [15:0] LIMIT_RST = 16'hffff;
  localparam logic [15:0] VWIN_RST  = 16'hf010;
  localparam logic [15:0] TWIN_RST  = 16'hc040;
endpackage

/* File: design/csc_min.sv */
`timescale 1ns/1ns
// lower of pin and register limit; pin ignored when its enable is clear
module csc_min (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic [7:0] pin_val,
  input  wire logic [7:0] reg_val,
  input  wire logic       pin_en,
  output logic      [7:0] eff
);
  logic [7:0] next_eff;

  always_comb begin
    next_eff = reg_val;
    if (pin_en && (pin_val < reg_val)) begin
      next_eff = pin_val;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      eff <= 8'h00;
    end else begin
      eff <= next_eff;
    end
  end
endmodule // csc_min

/* File: design/csc_pulse.sv */
`timescale 1ns/1ns
// fixed-width active-low pulse; triggers arriving mid-pulse are merged into it
module csc_pulse #(
  parameter int unsigned CYCLES = csc_pkg::ALERT_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic start,
  output logic      pulse_n
);
  typedef enum logic [1:0] {
    CSC_IDLE = 2'b01,
    CSC_BUSY = 2'b10
  } csc_pst_t;

  csc_pst_t                          state;
  logic     [csc_pkg::CNT_W-1:0]     count;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state   <= CSC_IDLE;
      count   <= '0;
      pulse_n <= 1'b1;
    end else begin
      case (state)
        CSC_IDLE: begin
          if (start) begin
            state   <= CSC_BUSY;
            count   <= csc_pkg::CNT_W'(CYCLES - 1);
            pulse_n <= 1'b0;
          end
        end
        CSC_BUSY: begin
          if (count == '0) begin
            state   <= CSC_IDLE;
            pulse_n <= 1'b1;
          end else begin
            count <= count - 1'b1;
          end
        end
        default: begin
          state   <= CSC_IDLE;
          pulse_n <= 1'b1;
        end
      endcase
    end
  end
endmodule // csc_pulse

/* File: design/csc_top.sv */
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module csc_top #(
  parameter int unsigned ALERT_CYCLES = csc_pkg::ALERT_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  charger_state,
  input  wire logic [7:0]  input_voltage,
  input  wire logic [7:0]  thermistor_sense,
  input  wire logic [7:0]  charge_current_pin,
  input  wire logic [7:0]  input_limit_pin,
  input  wire logic        input_limit_pin_high,
  input  wire logic        charge_allow_n_in,
  output logic             charge_allow_n_out,
  output logic             charge_allow_n_oe_n,
  output logic             charge_status_out_a,
  output logic             charge_status_out_a_oe_n,
  output logic             charge_status_out_b,
  output logic             charge_status_out_b_oe_n,
  output logic             input_source_ok_n,
  output logic             input_source_ok_n_oe_n,
  output logic             host_alert_n,
  output logic             host_alert_n_oe_n,
  output logic             charge_active,
  output logic             high_impedance_mode,
  output logic [7:0]       charge_limit_eff,
  output logic [7:0]       input_limit_eff,
  output logic             irq
);
  logic [11:0]            ctrl;
  logic [15:0]            limits;
  logic [15:0]            vwin;
  logic [15:0]            twin;
  logic [csc_pkg::EV_N-1:0] int_st;
  logic [csc_pkg::EV_N-1:0] int_en;
  logic [csc_pkg::EV_N-1:0] ev;
  logic [1:0]             prev_state;
  logic                   prev_inok;
  logic                   prev_temp;
  logic                   prev_hiz;
  logic                   input_ok;
  logic                   temp_ok;
  logic                   next_hiz;
  logic                   next_charge;
  logic                   wr_en;
  logic                   alert_pulse_n;
  logic [31:0]            next_rdata;
  logic                   next_err;

  logic charge_enable_bit;
  logic status_pins_off;
  logic input_ok_pin_off;
  logic allow_pin_off;
  logic charge_limit_pin_en;
  logic input_limit_pin_en;
  logic force_indicator_a;
  logic force_indicator_b;
  logic force_indicator_c;
  logic force_indicator_d;

  assign charge_enable_bit   = ctrl[csc_pkg::B_CHG_EN];
  assign status_pins_off     = ctrl[csc_pkg::B_STAT_OFF];
  assign input_ok_pin_off    = ctrl[csc_pkg::B_OK_OFF];
  assign allow_pin_off       = ctrl[csc_pkg::B_ALW_OFF];
  assign charge_limit_pin_en = ctrl[csc_pkg::B_CLIM_EN];
  assign input_limit_pin_en  = ctrl[csc_pkg::B_ILIM_EN];
  assign force_indicator_a   = ctrl[csc_pkg::B_FORCE_A];
  assign force_indicator_b   = ctrl[csc_pkg::B_FORCE_B];
  assign force_indicator_c   = ctrl[csc_pkg::B_FORCE_C];
  assign force_indicator_d   = ctrl[csc_pkg::B_FORCE_D];

  // apb: no wait states, answer registered in the setup cycle
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    next_err   = 1'b0;
    next_rdata = 32'h0000_0000;
    case (paddr)
      csc_pkg::OFS_CTRL:    next_rdata = {20'h00000, ctrl};
      csc_pkg::OFS_LIMIT:   next_rdata = {16'h0000, limits};
      csc_pkg::OFS_VWIN:    next_rdata = {16'h0000, vwin};
      csc_pkg::OFS_TWIN:    next_rdata = {16'h0000, twin};
      csc_pkg::OFS_STATUS:  next_rdata = {26'h0000000, charger_state, prev_hiz,
                                          temp_ok, input_ok, charge_active};
      csc_pkg::OFS_EFF:     next_rdata = {16'h0000, input_limit_eff, charge_limit_eff};
      csc_pkg::OFS_INT_ST:  next_rdata = {28'h0000000, int_st};
      csc_pkg::OFS_INT_CLR: next_rdata = 32'h0000_0000;
      csc_pkg::OFS_INT_EN:  next_rdata = {28'h0000000, int_en};
      default:              next_err   = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && next_err;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl   <= csc_pkg::CTRL_RST;
      limits <= csc_pkg::LIMIT_RST;
      vwin   <= csc_pkg::VWIN_RST;
      twin   <= csc_pkg::TWIN_RST;
      int_en <= '0;
    end else if (wr_en) begin
      case (paddr)
        csc_pkg::OFS_CTRL:   ctrl   <= pwdata[11:0];
        csc_pkg::OFS_LIMIT:  limits <= pwdata[15:0];
        csc_pkg::OFS_VWIN:   vwin   <= pwdata[15:0];
        csc_pkg::OFS_TWIN:   twin   <= pwdata[15:0];
        csc_pkg::OFS_INT_EN: int_en <= pwdata[csc_pkg::EV_N-1:0];
        default: begin
        end
      endcase
    end
  end

  // window compares: low byte is lower bound, high byte upper bound
  assign input_ok = (input_voltage >= vwin[7:0]) && (input_voltage <= vwin[15:8]);
  assign temp_ok  = (thermistor_sense >= twin[7:0]) &&
                    (thermistor_sense <= twin[15:8]);

  csc_min u_chg_min (
    .clock   (clock),
    .reset_n (reset_n),
    .pin_val (charge_current_pin),
    .reg_val (limits[7:0]),
    .pin_en  (charge_limit_pin_en),
    .eff     (charge_limit_eff)
  );

  csc_min u_in_min (
    .clock   (clock),
    .reset_n (reset_n),
    .pin_val (input_limit_pin),
    .reg_val (limits[15:8]),
    .pin_en  (input_limit_pin_en),
    .eff     (input_limit_eff)
  );

  assign next_hiz = input_limit_pin_en && input_limit_pin_high;
  // board keeps charge_allow_n defined, so no filtering is applied
  assign next_charge = charge_enable_bit && (allow_pin_off || !charge_allow_n_in) &&
                       temp_ok && !next_hiz;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      high_impedance_mode <= 1'b0;
      charge_active       <= 1'b0;
    end else begin
      high_impedance_mode <= next_hiz;
      charge_active       <= next_charge;
    end
  end

  // open-drain pins: level always 0, enable low pulls the line down
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      charge_status_out_a      <= 1'b0;
      charge_status_out_b      <= 1'b0;
      input_source_ok_n        <= 1'b0;
      charge_allow_n_out       <= 1'b0;
      host_alert_n_oe_n        <= 1'b1;
      charge_status_out_a_oe_n <= 1'b1;
      charge_status_out_b_oe_n <= 1'b1;
      input_source_ok_n_oe_n   <= 1'b1;
      charge_allow_n_oe_n      <= 1'b1;
    end else begin
      host_alert_n_oe_n        <= alert_pulse_n;
      charge_status_out_a_oe_n <= status_pins_off ? !force_indicator_a
                                                  : !charger_state[0];
      charge_status_out_b_oe_n <= status_pins_off ? !force_indicator_b
                                                  : !charger_state[1];
      input_source_ok_n_oe_n   <= input_ok_pin_off ? !force_indicator_c
                                                   : !input_ok;
      charge_allow_n_oe_n      <= allow_pin_off ? !force_indicator_d : 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      prev_state <= 2'b00;
      prev_inok  <= 1'b0;
      prev_temp  <= 1'b1;
      prev_hiz   <= 1'b0;
    end else begin
      prev_state <= charger_state;
      prev_inok  <= input_ok;
      prev_temp  <= temp_ok;
      prev_hiz   <= next_hiz;
    end
  end

  assign ev[csc_pkg::EV_STATE] = prev_state != charger_state;
  assign ev[csc_pkg::EV_INOK]  = prev_inok != input_ok;
  assign ev[csc_pkg::EV_TEMP]  = prev_temp && !temp_ok;
  assign ev[csc_pkg::EV_HIZ]   = prev_hiz != next_hiz;

  // set wins over a clear landing in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < csc_pkg::EV_N; gi++) begin : g_int
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          int_st[gi] <= 1'b0;
        end else if (ev[gi]) begin
          int_st[gi] <= 1'b1;
        end else if (wr_en && paddr == csc_pkg::OFS_INT_CLR && pwdata[gi]) begin
          int_st[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq          <= 1'b0;
      host_alert_n <= 1'b0;
    end else begin
      irq          <= |(int_st & int_en);
      host_alert_n <= 1'b0;
    end
  end

  csc_pulse #(
    .CYCLES (ALERT_CYCLES)
  ) u_alert (
    .clock   (clock),
    .reset_n (reset_n),
    .start   (|ev),
    .pulse_n (alert_pulse_n)
  );

  AST_STAT_A: assert property (@(posedge clock) disable iff (!reset_n)
    !status_pins_off ##1 !status_pins_off |-> charge_status_out_a_oe_n == !$past(charger_state[0]))
    else $error("status a not following charger state");
  AST_STAT_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    status_pins_off |=> charge_status_out_b_oe_n == !$past(force_indicator_b))
    else $error("status b not following force bit");
  AST_FORCE_A: assert property (@(posedge clock) disable iff (!reset_n)
    (status_pins_off && force_indicator_a) |=> !charge_status_out_a_oe_n)
    else $error("forced status a not pulled low");
  AST_INOK: assert property (@(posedge clock) disable iff (!reset_n)
    (!input_ok_pin_off && input_ok) |=> !input_source_ok_n_oe_n)
    else $error("input good not pulled low");
  AST_INOK_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    input_ok_pin_off |=> input_source_ok_n_oe_n == !$past(force_indicator_c))
    else $error("input good pin not following force bit");
  AST_CHG_EN: assert property (@(posedge clock) disable iff (!reset_n)
    (!charge_enable_bit || (!allow_pin_off && charge_allow_n_in)) |=> !charge_active)
    else $error("charging without enable");
  AST_ALLOW_IND: assert property (@(posedge clock) disable iff (!reset_n)
    !allow_pin_off |=> charge_allow_n_oe_n)
    else $error("allow pin driven while an input");
  AST_TEMP: assert property (@(posedge clock) disable iff (!reset_n)
    !temp_ok |=> !charge_active)
    else $error("charging outside temperature window");
  AST_CLIM: assert property (@(posedge clock) disable iff (!reset_n)
    !charge_limit_pin_en |=> charge_limit_eff == $past(limits[7:0]))
    else $error("charge limit not register only");
  AST_ILIM: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1 |=> input_limit_eff <= $past(limits[15:8]))
    else $error("input limit above register");
  AST_HIZ: assert property (@(posedge clock) disable iff (!reset_n)
    (input_limit_pin_en && input_limit_pin_high) |=> high_impedance_mode && !charge_active)
    else $error("high impedance not entered");
  AST_ALERT: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(alert_pulse_n) |-> !alert_pulse_n [*8])
    else $error("alert pulse too short");

  // status pins and indicators
  AST_STAT_B: assert property (@(posedge clock) disable iff (!reset_n)
    !status_pins_off ##1 !status_pins_off |-> charge_status_out_b_oe_n == !$past(charger_state[1]))
    else $error("status b not following charger state");
  AST_STAT_OFF_A: assert property (@(posedge clock) disable iff (!reset_n)
    status_pins_off |=> charge_status_out_a_oe_n == !$past(force_indicator_a))
    else $error("status a not following force bit");
  AST_FORCE_B: assert property (@(posedge clock) disable iff (!reset_n)
    (status_pins_off && force_indicator_b) |=> !charge_status_out_b_oe_n)
    else $error("forced status b not pulled low");
  AST_INOK_REL: assert property (@(posedge clock) disable iff (!reset_n)
    (!input_ok_pin_off && !input_ok) |=> input_source_ok_n_oe_n)
    else $error("input good pulled low outside window");
  AST_ALLOW_FORCE: assert property (@(posedge clock) disable iff (!reset_n)
    allow_pin_off |=> charge_allow_n_oe_n == !$past(force_indicator_d))
    else $error("allow pin not following force bit");

  // charging gate; allow pin ignored while its function is off
  AST_ALLOW_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    (charge_enable_bit && allow_pin_off && temp_ok && !input_limit_pin_high) |=> charge_active)
    else $error("charging blocked by ignored allow pin");

  // limits and high-impedance forcing
  AST_CLIM_MIN: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1 |=> charge_limit_eff <= $past(limits[7:0]))
    else $error("charge limit above register");
  AST_ILIM_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    !input_limit_pin_en |=> input_limit_eff == $past(limits[15:8]))
    else $error("input limit not register only");
  AST_HIZ_OFF: assert property (@(posedge clock) disable iff (!reset_n)
    !input_limit_pin_en |=> !high_impedance_mode)
    else $error("high impedance entered with pin disabled");

  // alert pin, interrupt and bus answer
  AST_ALERT_PIN: assert property (@(posedge clock) disable iff (!reset_n)
    !alert_pulse_n |=> !host_alert_n_oe_n)
    else $error("alert pin not pulled low during pulse");
  AST_IRQ_LOW: assert property (@(posedge clock) disable iff (!reset_n)
    !(|(int_st & int_en)) |=> !irq)
    else $error("interrupt without enabled status");
  AST_PREADY: assert property (@(posedge clock) disable iff (!reset_n)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
endmodule // csc_top

/* File: verif/csc_board.sv */
`timescale 1ns/1ns
// board side: pull-ups on every open-drain pin, plus whatever holds the allow pin
module csc_board (
  input  wire logic allow_oe_n,
  input  wire logic stat_a_oe_n,
  input  wire logic stat_b_oe_n,
  input  wire logic ok_oe_n,
  input  wire logic alert_oe_n,
  input  wire logic board_drives,
  input  wire logic board_level,
  output logic      allow_wire,
  output logic      stat_a_wire,
  output logic      stat_b_wire,
  output logic      ok_wire,
  output logic      alert_wire
);
  // a released pin reads high through its pull-up
  assign stat_a_wire = stat_a_oe_n ? 1'h1 : 1'h0;
  assign stat_b_wire = stat_b_oe_n ? 1'h1 : 1'h0;
  assign ok_wire     = ok_oe_n ? 1'h1 : 1'h0;
  assign alert_wire  = alert_oe_n ? 1'h1 : 1'h0;
  // the board never floats the allow pin; a weak board level loses to the device pull-down
  assign allow_wire  = !allow_oe_n ? 1'h0 : (board_drives ? board_level : 1'h1);
endmodule // csc_board

/* File: verif/csc_top_bench.sv */
`timescale 1ns/1ns
module csc_top_bench;
  localparam int unsigned AC = 16;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, input_voltage, thermistor_sense, charge_current_pin, input_limit_pin;
  logic [7:0]  charge_limit_eff, input_limit_eff, ofs[5];
  logic [31:0] pwdata, prdata, rd, rst[5];
  logic [1:0]  charger_state;
  logic        input_limit_pin_high, allow_wire, allow_oe_n, a_oe_n, b_oe_n, ok_oe_n, al_oe_n;
  logic        a_wire, b_wire, ok_wire, al_wire, charge_active, high_impedance_mode, irq;
  logic        board_drives, board_level;
  int          bad_count, total_checks, n;

  csc_top #(.ALERT_CYCLES(AC)) csc_top_inst (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .charger_state(charger_state), .input_voltage(input_voltage),
    .thermistor_sense(thermistor_sense), .charge_current_pin(charge_current_pin),
    .input_limit_pin(input_limit_pin), .input_limit_pin_high(input_limit_pin_high),
    .charge_allow_n_in(allow_wire), .charge_allow_n_out(), .charge_allow_n_oe_n(allow_oe_n),
    .charge_status_out_a(), .charge_status_out_a_oe_n(a_oe_n),
    .charge_status_out_b(), .charge_status_out_b_oe_n(b_oe_n),
    .input_source_ok_n(), .input_source_ok_n_oe_n(ok_oe_n),
    .host_alert_n(), .host_alert_n_oe_n(al_oe_n), .charge_active(charge_active),
    .high_impedance_mode(high_impedance_mode), .charge_limit_eff(charge_limit_eff),
    .input_limit_eff(input_limit_eff), .irq(irq)
  );

  csc_board csc_board_inst (
    .allow_oe_n(allow_oe_n), .stat_a_oe_n(a_oe_n), .stat_b_oe_n(b_oe_n), .ok_oe_n(ok_oe_n),
    .alert_oe_n(al_oe_n), .board_drives(board_drives), .board_level(board_level),
    .allow_wire(allow_wire), .stat_a_wire(a_wire), .stat_b_wire(b_wire), .ok_wire(ok_wire),
    .alert_wire(al_wire)
  );

  task automatic report_and_stop;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_pin(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // waits up to 100 edges for pready; reaching the 100th edge is counted as a failure, even if pready arrives on it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'h1 && k < 100);
    if (k >= 100) begin
      bad_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // status and limit outputs follow a cause one edge later, irq and the alert pin two; three edges cover a register write too
  task automatic settle;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, charger_state} = '0;
    {input_limit_pin_high, board_level, bad_count, total_checks} = '0;
    board_drives = 1'h1;
    input_voltage = 8'h80;
    thermistor_sense = 8'h80;
    charge_current_pin = 8'hff;
    input_limit_pin = 8'hff;
    ofs = '{csc_pkg::OFS_CTRL, csc_pkg::OFS_LIMIT, csc_pkg::OFS_VWIN, csc_pkg::OFS_TWIN,
            csc_pkg::OFS_INT_CLR};
    rst = '{32'h31, 32'hffff, 32'hf010, 32'hc040, 32'h0};
    repeat (6) @(posedge clock);
    reset_n <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, ofs[i], 32'h0);
      check_word("register reset", rst[i], rd);
    end
    apb(1'h1, 8'h24, 32'hffffffff);
    check_pin("unmapped write error", 1'h1, err);
    apb(1'h0, 8'h24, 32'h0);
    check_word("unmapped read", 32'h0, rd);
    settle();
    check_pin("charging", 1'h1, charge_active);
    @(posedge clock) board_level <= 1'h1;
    settle();
    check_pin("allow pin high", 1'h0, charge_active);
    @(posedge clock) board_level <= 1'h0;
    apb(1'h1, csc_pkg::OFS_CTRL, 32'h30);
    settle();
    check_pin("enable bit clear", 1'h0, charge_active);
    apb(1'h1, csc_pkg::OFS_CTRL, 32'h31);
    // window edges are inclusive
    for (int i = 0; i < 4; i++) begin
      @(posedge clock) thermistor_sense <= i[0] ? (i[1] ? 8'hc0 : 8'h40) : (i[1] ? 8'hc1 : 8'h3f);
      settle();
      check_pin("temperature window", i[0], charge_active);
      @(posedge clock) input_voltage <= i[0] ? (i[1] ? 8'hf0 : 8'h10) : (i[1] ? 8'hf1 : 8'h0f);
      settle();
      check_pin("input good", !i[0], ok_wire);
    end
    @(posedge clock) input_voltage <= 8'h80;
    for (int s = 0; s < 4; s++) begin
      @(posedge clock) charger_state <= s[1:0];
      settle();
      check_pin("status a", !s[0], a_wire);
      check_pin("status b", !s[1], b_wire);
    end
    for (int j = 0; j < 2; j++) begin
      apb(1'h1, csc_pkg::OFS_CTRL, j[0] ? 32'h233 : 32'h133);
      @(posedge clock) charger_state <= j[0] ? 2'h1 : 2'h2;
      settle();
      check_pin("indicator a", j[0], a_wire);
      check_pin("indicator b", !j[0], b_wire);
    end
    apb(1'h1, csc_pkg::OFS_CTRL, 32'h435);
    @(posedge clock) input_voltage <= 8'h05;
    settle();
    check_pin("indicator c on", 1'h0, ok_wire);
    apb(1'h1, csc_pkg::OFS_CTRL, 32'h35);
    @(posedge clock) input_voltage <= 8'h80;
    settle();
    check_pin("indicator c off", 1'h1, ok_wire);
    @(posedge clock) board_drives <= 1'h0;
    apb(1'h1, csc_pkg::OFS_CTRL, 32'h839);
    settle();
    check_pin("indicator d on", 1'h0, allow_wire);
    check_pin("allow ignored", 1'h1, charge_active);
    apb(1'h1, csc_pkg::OFS_CTRL, 32'h39);
    @(posedge clock) board_drives <= 1'h1;
    board_level <= 1'h1;
    settle();
    check_pin("allow ignored high", 1'h1, charge_active);
    apb(1'h1, csc_pkg::OFS_CTRL, 32'h31);
    @(posedge clock) board_level <= 1'h0;
    apb(1'h1, csc_pkg::OFS_LIMIT, 32'h5040);
    for (int r = 0; r < 3; r++) begin
      apb(1'h1, csc_pkg::OFS_CTRL, r == 2 ? 32'h1 : 32'h31);
      @(posedge clock) charge_current_pin <= r == 0 ? 8'h30 : (r == 1 ? 8'h50 : 8'h10);
      input_limit_pin <= r == 0 ? 8'h60 : (r == 1 ? 8'h20 : 8'h10);
      settle();
      check_word("charge limit", r == 0 ? 32'h30 : 32'h40, {24'h0, charge_limit_eff});
      check_word("input limit", r == 1 ? 32'h20 : 32'h50, {24'h0, input_limit_eff});
    end
    apb(1'h0, csc_pkg::OFS_EFF, 32'h0);
    check_word("effective limits", 32'h5040, rd);
    check_pin("mapped read error", 1'h0, err);
    @(posedge clock) input_limit_pin_high <= 1'h1;
    settle();
    check_pin("high-z pin ignored", 1'h0, high_impedance_mode);
    apb(1'h1, csc_pkg::OFS_CTRL, 32'h31);
    settle();
    check_pin("high-z forced", 1'h1, high_impedance_mode);
    check_pin("high-z stops charge", 1'h0, charge_active);
    @(posedge clock) input_limit_pin_high <= 1'h0;
    repeat (40) @(posedge clock);
    apb(1'h1, csc_pkg::OFS_INT_CLR, 32'hf);
    apb(1'h1, csc_pkg::OFS_INT_EN, 32'h1);
    @(posedge clock) charger_state <= 2'h2;
    n = 0;
    while (al_wire !== 1'h0 && n < 10) begin
      @(negedge clock);
      n++;
    end
    n = 0;
    while (al_wire === 1'h0 && n < 100) begin
      @(negedge clock);
      n++;
    end
    check_word("alert width", AC, n);
    check_pin("irq raised", 1'h1, irq);
    apb(1'h0, csc_pkg::OFS_INT_ST, 32'h0);
    check_word("event status", 32'h1, rd);
    apb(1'h1, csc_pkg::OFS_INT_CLR, 32'h1);
    settle();
    check_pin("irq cleared", 1'h0, irq);
    apb(1'h1, csc_pkg::OFS_INT_EN, 32'h0);
    @(posedge clock) charger_state <= 2'h3;
    settle();
    check_pin("irq masked", 1'h0, irq);
    apb(1'h0, csc_pkg::OFS_INT_ST, 32'h0);
    check_word("masked status", 32'h1, rd);
    report_and_stop();
  end
endmodule // csc_top_bench
